/* design/rel_pkg.sv */
//----------------------------------------------------------------------
// Purpose : shared constants for the rgmii lpi signalling ends
// Assumes : byte-wide transfer model of the ddr link
// Notes   : timing counts derived from the reference clock rate
//----------------------------------------------------------------------
package rel_pkg;
  localparam int          REF_CLK_MHZ      = 100;
  localparam int          LINK_DIV         = 2;
  localparam logic [7:0]  LPI_BYTE         = 8'h01;
  localparam logic [3:0]  LPI_NIB_RISE     = 4'h1;
  localparam logic [3:0]  LPI_NIB_FALL     = 4'h0;
  localparam int          CLK_STOP_CYC     = 10;
  localparam int          REFRESH_US_MIN   = 200;
  localparam int          QUIET_MS_MIN     = 20;
  localparam int          REFRESH_CYC      = REFRESH_US_MIN * REF_CLK_MHZ;
  localparam int          QUIET_CYC        = QUIET_MS_MIN * 1000
                                             * REF_CLK_MHZ;
  localparam logic [1:0]  CODE_IDLE        = 2'h0;
  localparam logic [1:0]  CODE_DATA        = 2'h1;
  localparam logic [1:0]  CODE_REFRESH     = 2'h2;
  typedef enum logic [1:0] {
    REL_RX_NORM = 2'b00,
    REL_RX_LPI  = 2'b01,
    REL_RX_STOP = 2'b11,
    REL_RX_WAKE = 2'b10
  } rel_rx_state_t;
endpackage : rel_pkg

/* design/rel_link_if.sv */
//----------------------------------------------------------------------
// Purpose : rgmii link between mac end and phy end
// Assumes : ddr nibbles modelled as both halves per link clock edge
// Notes   : rxc is gated by the phy, txc by the mac
//----------------------------------------------------------------------
`timescale 1ns/100ps
interface rel_link_if;
  logic       txc;
  logic       tx_en;
  logic       tx_er;
  logic [3:0] txd_rise;
  logic [3:0] txd_fall;
  logic       rxc;
  logic       rx_dv;
  logic       rx_er;
  logic [3:0] rxd_rise;
  logic [3:0] rxd_fall;
  logic       clk_stop_ok;
  modport mac (output txc, tx_en, tx_er, txd_rise, txd_fall,
               input rxc, rx_dv, rx_er, rxd_rise, rxd_fall, clk_stop_ok);
  modport phy (input txc, tx_en, tx_er, txd_rise, txd_fall,
               output rxc, rx_dv, rx_er, rxd_rise, rxd_fall, clk_stop_ok);
endinterface : rel_link_if

/* design/rel_phy_end.sv */
//----------------------------------------------------------------------
// Purpose : phy end: transmit and receive lpi tracking, rxc gating,
//           refresh timing, eee advertisement
// Assumes : line codes arrive on the link clock domain
// Notes   : tx path runs on txc, everything else on rx link clock
//----------------------------------------------------------------------
// Summary of operation
// R01 - tx_en rise, tx_er fall, nibbles low then high
// R02 - gigabit lpi: en low, er high, byte 01
// R03 - hold tx lpi while pattern held exactly
// R04 - mac stops txc after ten lpi cycles
// R05 - fast mode: data nibble on rising edge
// R06 - fast mode lpi: en low, er high, 0001
// R07 - fast mode txc stop after ten cycles
// R08 - drive dv rise, er fall, nibbles low/high
// R09 - refresh code enters rx lpi pattern
// R10 - leave rx lpi on non-refresh code
// R11 - stop rxc after ten rx lpi cycles
// R12 - separate tx and rx lpi state
// R13 - refresh burst 200us every 20ms
// R14 - eee on at reset, cleared plus restart
// R15 - resume normal operation at once
// R16 - restart rxc first, clear lpi counts
`timescale 1ns/100ps
module rel_phy_end
  import rel_pkg::*;
#(
  parameter int REFRESH_CYCLES = rel_pkg::REFRESH_CYC,
  parameter int QUIET_CYCLES   = rel_pkg::QUIET_CYC
) (
  // clocks and reset
  input  wire logic       rx_link_clk_in,
  input  wire logic       rst_in,
  // link
  rel_link_if.phy         link,
  // line side
  input  wire logic       gig_mode_in,
  input  wire logic [1:0] line_code_in,
  input  wire logic [7:0] line_data_in,
  input  wire logic       clk_stop_en_in,
  input  wire logic       adv_1000_in,
  input  wire logic       adv_100_in,
  input  wire logic       autoneg_restart_bit_in,
  // status
  output logic            tx_lpi_out,
  output logic            rx_lpi_out,
  output logic            eee_active_out,
  output logic            refresh_burst_out,
  output logic [7:0]      tx_byte_out,
  output logic            tx_byte_valid_out
);
  import rel_pkg::*;

  //--------------------------------------------------------------------
  // transmit capture on txc
  //--------------------------------------------------------------------
  logic tx_lpi_r;
  logic tx_lpi_nxt;
  logic [7:0] tx_byte_r;
  logic tx_valid_r;

  always_comb begin
    if (gig_mode_in) begin
      tx_lpi_nxt = !link.tx_en && link.tx_er &&
                   {link.txd_fall, link.txd_rise} == LPI_BYTE; // [R02]
    end else begin
      tx_lpi_nxt = !link.tx_en && link.tx_er &&
                   link.txd_rise == LPI_NIB_RISE; // [R06]
    end
  end

  always_ff @(posedge link.txc or posedge rst_in) begin
    if (rst_in) begin
      tx_lpi_r   <= 1'b0;
      tx_byte_r  <= 8'h00;
      tx_valid_r <= 1'b0;
    end else begin
      tx_lpi_r   <= tx_lpi_nxt; // [R03] [R12]
      tx_valid_r <= link.tx_en; // [R15]
      if (gig_mode_in) begin
        tx_byte_r <= {link.txd_fall, link.txd_rise}; // [R01]
      end else begin
        tx_byte_r <= {4'h0, link.txd_rise}; // [R05]
      end
    end
  end
  assign tx_byte_out       = tx_byte_r;
  assign tx_byte_valid_out = tx_valid_r;

  // tx lpi level crosses into the rx link domain
  logic tx_lpi_s1_r;
  logic tx_lpi_s2_r;
  always_ff @(posedge rx_link_clk_in or posedge rst_in) begin
    if (rst_in) begin
      tx_lpi_s1_r <= 1'b0;
      tx_lpi_s2_r <= 1'b0;
    end else begin
      tx_lpi_s1_r <= tx_lpi_r;
      tx_lpi_s2_r <= tx_lpi_s1_r;
    end
  end
  assign tx_lpi_out = tx_lpi_s2_r;

  //--------------------------------------------------------------------
  // eee advertisement
  //--------------------------------------------------------------------
  logic eee_r;
  always_ff @(posedge rx_link_clk_in or posedge rst_in) begin
    if (rst_in) begin
      eee_r <= 1'b1; // [R14]
    end else if (autoneg_restart_bit_in) begin
      eee_r <= adv_1000_in || adv_100_in; // [R14]
    end
  end
  assign eee_active_out = eee_r;

  //--------------------------------------------------------------------
  // receive lpi state machine
  //--------------------------------------------------------------------
  rel_rx_state_t rx_st_r;
  logic [3:0]    lpi_cnt_r;
  logic          is_refresh;
  assign is_refresh = eee_r && line_code_in == CODE_REFRESH;

  always_ff @(posedge rx_link_clk_in or posedge rst_in) begin
    if (rst_in) begin
      rx_st_r   <= REL_RX_NORM;
      lpi_cnt_r <= 4'h0;
    end else begin
      case (rx_st_r)
        REL_RX_NORM: begin
          lpi_cnt_r <= 4'h0;
          if (is_refresh) begin
            rx_st_r <= REL_RX_LPI; // [R09]
          end
        end
        REL_RX_LPI: begin
          if (!is_refresh) begin
            rx_st_r   <= REL_RX_NORM; // [R10] [R15]
            lpi_cnt_r <= 4'h0; // [R16]
          end else if (lpi_cnt_r < 4'(CLK_STOP_CYC)) begin
            lpi_cnt_r <= lpi_cnt_r + 4'h1;
          end else if (clk_stop_en_in) begin
            rx_st_r <= REL_RX_STOP; // [R11]
          end
        end
        REL_RX_STOP: begin
          if (!is_refresh) begin
            rx_st_r   <= REL_RX_WAKE; // [R16]
            lpi_cnt_r <= 4'h0; // [R16]
          end
        end
        REL_RX_WAKE: begin
          rx_st_r <= REL_RX_NORM; // [R16]
        end
        default: begin
          rx_st_r <= REL_RX_NORM;
        end
      endcase
    end
  end
  assign rx_lpi_out = rx_st_r == REL_RX_LPI || rx_st_r == REL_RX_STOP;

  //--------------------------------------------------------------------
  // two-entry receive buffer ahead of the output registers
  //--------------------------------------------------------------------
  logic [7:0] buf_mem [2];
  logic       wr_ptr_r;
  logic       rd_ptr_r;
  logic [1:0] cnt_r;
  logic       buf_push;
  logic       buf_pop;
  logic       out_ready;
  assign out_ready = rx_st_r == REL_RX_NORM;
  assign buf_push  = line_code_in == CODE_DATA && cnt_r != 2'h2;
  assign buf_pop   = out_ready && cnt_r != 2'h0;

  always_ff @(posedge rx_link_clk_in or posedge rst_in) begin
    if (rst_in) begin
      wr_ptr_r <= 1'b0;
      rd_ptr_r <= 1'b0;
      cnt_r    <= 2'h0;
    end else begin
      if (buf_push) begin
        wr_ptr_r <= !wr_ptr_r;
      end
      if (buf_pop) begin
        rd_ptr_r <= !rd_ptr_r;
      end
      cnt_r <= cnt_r + 2'(buf_push) - 2'(buf_pop);
    end
  end
  always_ff @(posedge rx_link_clk_in) begin
    if (buf_push) begin
      buf_mem[wr_ptr_r] <= line_data_in;
    end
  end

  //--------------------------------------------------------------------
  // receive output drive
  //--------------------------------------------------------------------
  logic       rx_dv_r;
  logic       rx_er_r;
  logic [7:0] rxd_r;
  always_ff @(posedge rx_link_clk_in or posedge rst_in) begin
    if (rst_in) begin
      rx_dv_r <= 1'b0;
      rx_er_r <= 1'b0;
      rxd_r   <= 8'h00;
    end else if (rx_lpi_out || (rx_st_r == REL_RX_NORM && is_refresh)) begin
      rx_dv_r <= 1'b0; // [R09]
      rx_er_r <= 1'b1; // [R09]
      rxd_r   <= {LPI_NIB_FALL, LPI_NIB_RISE}; // [R09] [R10]
    end else if (buf_pop) begin
      rx_dv_r <= 1'b1; // [R08]
      rx_er_r <= 1'b0;
      rxd_r   <= gig_mode_in ? buf_mem[rd_ptr_r][7:0]
                             : {4'h0, buf_mem[rd_ptr_r][3:0]};
    end else begin
      rx_dv_r <= 1'b0;
      rx_er_r <= 1'b0;
      rxd_r   <= 8'h00;
    end
  end
  assign link.rx_dv       = rx_dv_r;
  assign link.rx_er       = rx_er_r;
  assign link.rxd_rise    = rxd_r[3:0]; // [R08]
  assign link.rxd_fall    = rxd_r[7:4]; // [R08]
  // rxc gating: glitch risk accepted for this model, clock held low
  assign link.rxc         = rx_link_clk_in && rx_st_r != REL_RX_STOP; // [R11]
  assign link.clk_stop_ok = clk_stop_en_in;

  //--------------------------------------------------------------------
  // refresh timing while in lpi
  //--------------------------------------------------------------------
  logic [31:0] ref_cnt_r;
  logic        in_lpi;
  assign in_lpi = rx_lpi_out || tx_lpi_s2_r; // [R12]
  always_ff @(posedge rx_link_clk_in or posedge rst_in) begin
    if (rst_in) begin
      ref_cnt_r <= 32'h0;
    end else if (!in_lpi) begin
      ref_cnt_r <= 32'h0; // [R16]
    end else if (ref_cnt_r >= 32'(QUIET_CYCLES + REFRESH_CYCLES - 1)) begin
      ref_cnt_r <= 32'h0;
    end else begin
      ref_cnt_r <= ref_cnt_r + 32'h1; // [R13]
    end
  end
  assign refresh_burst_out = in_lpi &&
                             ref_cnt_r >= 32'(QUIET_CYCLES); // [R13]
endmodule : rel_phy_end

/* design/rel_mac_end.sv */
//----------------------------------------------------------------------
// Purpose : mac end: drives tx frames or lpi, stops txc when allowed
// Assumes : txc derived from ref clock by divide-by-two
// Notes   : receive side sampled through two flops
//----------------------------------------------------------------------
`timescale 1ns/100ps
module rel_mac_end
  import rel_pkg::*;
(
  // clocks and reset
  input  wire logic       ref_clk_in,
  input  wire logic       rst_in,
  // link
  rel_link_if.mac         link,
  // user side
  input  wire logic       gig_mode_in,
  input  wire logic       lpi_req_in,
  input  wire logic       tx_valid_in,
  input  wire logic [7:0] tx_data_in,
  output logic            tx_ready_out,
  output logic            rx_lpi_seen_out,
  output logic            txc_stopped_out
);
  import rel_pkg::*;

  //--------------------------------------------------------------------
  // txc divider and lpi hold counter
  //--------------------------------------------------------------------
  logic       div_r;
  logic [3:0] hold_r;
  logic       stop_r;
  logic       ok_s1_r;
  logic       ok_s2_r;
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      ok_s1_r <= 1'b0;
      ok_s2_r <= 1'b0;
    end else begin
      ok_s1_r <= link.clk_stop_ok;
      ok_s2_r <= ok_s1_r;
    end
  end
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      div_r  <= 1'b0;
      hold_r <= 4'h0;
      stop_r <= 1'b0;
    end else begin
      div_r <= stop_r ? 1'b0 : !div_r;
      if (!lpi_req_in) begin
        hold_r <= 4'h0;
        stop_r <= 1'b0;
      end else if (div_r && hold_r < 4'(CLK_STOP_CYC)) begin
        hold_r <= hold_r + 4'h1;
      end else if (hold_r >= 4'(CLK_STOP_CYC) && ok_s2_r && !div_r) begin
        stop_r <= 1'b1; // [R04] [R07]
      end
    end
  end
  assign link.txc        = div_r;
  assign txc_stopped_out = stop_r;

  //--------------------------------------------------------------------
  // transmit drive, updated when txc falls
  //--------------------------------------------------------------------
  logic       en_r;
  logic       er_r;
  logic [7:0] d_r;
  assign tx_ready_out = div_r && !lpi_req_in;
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      en_r <= 1'b0;
      er_r <= 1'b0;
      d_r  <= 8'h00;
    end else if (div_r) begin
      if (lpi_req_in) begin
        en_r <= 1'b0; // [R02] [R06]
        er_r <= 1'b1;
        d_r  <= LPI_BYTE;
      end else begin
        en_r <= tx_valid_in; // [R01] [R05]
        er_r <= 1'b0;
        d_r  <= tx_valid_in ? tx_data_in : 8'h00;
      end
    end
  end
  assign link.tx_en    = en_r;
  assign link.tx_er    = er_r;
  assign link.txd_rise = d_r[3:0];
  assign link.txd_fall = gig_mode_in ? d_r[7:4] : d_r[3:0];

  //--------------------------------------------------------------------
  // receive lpi detect
  //--------------------------------------------------------------------
  logic [5:0] s1_r;
  logic [5:0] s2_r;
  logic       seen_r;
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      s1_r   <= 6'h00;
      s2_r   <= 6'h00;
      seen_r <= 1'b0;
    end else begin
      // raw pins into the first flop: decoding ahead of it could glitch
      s1_r   <= {link.rx_dv, link.rx_er, link.rxd_rise};
      s2_r   <= s1_r;
      seen_r <= !s2_r[5] && s2_r[4] && s2_r[3:0] == LPI_NIB_RISE;
    end
  end
  assign rx_lpi_seen_out = seen_r;
endmodule : rel_mac_end

/* dv/rel_link_checker.sv */
// Purpose : link checks for the lpi signalling ends
// Assumes : txc toggles on every reference edge while it runs
// Notes   : clock stops are judged by small counters, not repeats
`timescale 1ns/100ps
module rel_link_checker (
  // clocks and reset
  input wire logic       ref_clk_in,
  input wire logic       rx_link_clk_in,
  input wire logic       rst_in,
  // link
  input wire logic       txc,
  input wire logic       tx_en,
  input wire logic       tx_er,
  input wire logic [3:0] txd_rise,
  input wire logic [3:0] txd_fall,
  input wire logic       rxc,
  input wire logic       rx_dv,
  input wire logic       rx_er,
  input wire logic [3:0] rxd_rise,
  input wire logic [3:0] rxd_fall,
  input wire logic       clk_stop_ok
);
  // ------------------------------------------------------------
  // helper counters
  // ------------------------------------------------------------
  logic       txc_q_r;
  logic [2:0] still_r;
  logic [3:0] tx_cnt_r;
  logic       tog_r;
  logic       tog_q_r;
  logic       seen_r;
  logic [3:0] rx_cnt_r;
  wire        tx_pat  = !tx_en && tx_er && txd_rise == 4'h1;
  wire        rx_pat  = !rx_dv && rx_er && rxd_rise == 4'h1;
  wire        rxc_ran = tog_r != tog_q_r;
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      txc_q_r  <= 1'b0;
      still_r  <= 3'h0;
      tx_cnt_r <= 4'h0;
    end else begin
      txc_q_r <= txc;
      if (txc != txc_q_r) still_r <= 3'h0;
      else if (still_r != 3'h7) still_r <= still_r + 3'h1;
      if (!tx_pat) tx_cnt_r <= 4'h0;
      else if (txc && !txc_q_r && tx_cnt_r != 4'hF)
        tx_cnt_r <= tx_cnt_r + 4'h1;
    end
  end
  // a toggle per rxc edge avoids sampling a gated clock directly
  always_ff @(posedge rxc or posedge rst_in) begin
    if (rst_in) tog_r <= 1'b0;
    else tog_r <= !tog_r;
  end
  always_ff @(posedge rx_link_clk_in or posedge rst_in) begin
    if (rst_in) begin
      tog_q_r  <= 1'b0;
      seen_r   <= 1'b0;
      rx_cnt_r <= 4'h0;
    end else begin
      tog_q_r <= tog_r;
      seen_r  <= seen_r | rxc_ran;
      if (!rx_pat) rx_cnt_r <= 4'h0;
      else if (rx_cnt_r != 4'hF) rx_cnt_r <= rx_cnt_r + 4'h1;
    end
  end
  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  a_tx_er_lpi : assert property (@(posedge ref_clk_in)
    disable iff (rst_in) tx_er |-> !tx_en && txd_rise == 4'h1)
    else $error("tx error outside lpi pattern");
  a_tx_en_hold : assert property (@(posedge ref_clk_in)
    disable iff (rst_in) $rose(tx_en) |=> tx_en)
    else $error("tx enable shorter than one txc period");
  a_txc_stop_ten : assert property (@(posedge ref_clk_in)
    disable iff (rst_in) still_r == 3'h6 |-> tx_cnt_r >= 4'hA)
    else $error("txc stopped before ten lpi cycles");
  a_txc_runs_data : assert property (@(posedge ref_clk_in)
    disable iff (rst_in) tx_en |-> ##[0:2] still_r == 3'h0)
    else $error("frame sent without txc");
  a_rx_er_lpi : assert property (@(posedge rx_link_clk_in)
    disable iff (rst_in) rx_er |-> !rx_dv && rxd_rise == 4'h1)
    else $error("rx error outside lpi pattern");
  a_rx_fall_nib : assert property (@(posedge rx_link_clk_in)
    disable iff (rst_in) rx_pat |-> rxd_fall inside {4'h0, 4'h1})
    else $error("rx lpi high nibble wrong");
  a_rxc_stop_ten : assert property (@(posedge rx_link_clk_in)
    disable iff (rst_in) seen_r && !rxc_ran |-> rx_cnt_r >= 4'hA)
    else $error("rxc stopped before ten lpi cycles");
  a_rxc_stop_en : assert property (@(posedge rx_link_clk_in)
    disable iff (rst_in) seen_r && !rxc_ran |-> clk_stop_ok)
    else $error("rxc stopped while clock stop disabled");
  a_rxc_before_dv : assert property (@(posedge rx_link_clk_in)
    disable iff (rst_in) $rose(rx_dv) |-> rxc_ran)
    else $error("rx data driven with rxc stopped");
  c_tx_lpi : cover property (@(posedge ref_clk_in) tx_cnt_r == 4'hA);
  c_rx_stop : cover property (@(posedge rx_link_clk_in) seen_r && !rxc_ran);
  c_rx_data : cover property (@(posedge rx_link_clk_in) $rose(rx_dv));
endmodule : rel_link_checker

/* dv/rgmii_eee_lpi_signaling_tb.sv */
// Purpose : directed bench joining the mac end and the phy end
// Assumes : short refresh and quiet counts set through parameters
// Notes   : inputs change 1 ns after the edge of their own clock
`timescale 1ns/100ps
module rgmii_eee_lpi_signaling_tb;
  import rel_pkg::*;
  localparam int RF = 4;
  localparam int QT = 20;
  logic       ref_clk_in = 1'b0;
  logic       rx_clk     = 1'b0;
  logic       rst_in     = 1'b1;
  logic       gig        = 1'b1;
  logic       lpi_req    = 1'b0;
  logic       tx_valid   = 1'b0;
  logic [7:0] tx_data    = 8'h00;
  logic [1:0] code       = CODE_IDLE;
  logic [7:0] ldata      = 8'h00;
  logic       stop_en    = 1'b1;
  logic       adv1000    = 1'b1;
  logic       adv100     = 1'b1;
  logic       restart    = 1'b0;
  logic       tx_lpi, rx_lpi, eee, burst, bvld, ready, rx_seen, stopped;
  logic [7:0] tx_byte;
  logic [7:0] got_q[$];
  int         bad_count  = 0;
  int         cmp_count  = 0;
  int         rxc_edges  = 0;
  rel_link_if link ();
  always #5 ref_clk_in = ~ref_clk_in;
  always #16 rx_clk = ~rx_clk;
  always @(posedge link.txc) if (bvld === 1'b1) got_q.push_back(tx_byte);
  always @(posedge link.rxc) rxc_edges++;
  rel_mac_end u_rel_mac_end (.ref_clk_in(ref_clk_in), .rst_in(rst_in),
    .link(link), .gig_mode_in(gig), .lpi_req_in(lpi_req),
    .tx_valid_in(tx_valid), .tx_data_in(tx_data), .tx_ready_out(ready),
    .rx_lpi_seen_out(rx_seen), .txc_stopped_out(stopped));
  rel_phy_end #(.REFRESH_CYCLES(RF), .QUIET_CYCLES(QT)) u_rel_phy_end (
    .rx_link_clk_in(rx_clk), .rst_in(rst_in), .link(link),
    .gig_mode_in(gig), .line_code_in(code), .line_data_in(ldata),
    .clk_stop_en_in(stop_en), .adv_1000_in(adv1000), .adv_100_in(adv100),
    .autoneg_restart_bit_in(restart), .tx_lpi_out(tx_lpi),
    .rx_lpi_out(rx_lpi), .eee_active_out(eee), .refresh_burst_out(burst),
    .tx_byte_out(tx_byte), .tx_byte_valid_out(bvld));
  rel_link_checker u_rel_link_checker (.ref_clk_in(ref_clk_in),
    .rx_link_clk_in(rx_clk), .rst_in(rst_in), .txc(link.txc),
    .tx_en(link.tx_en), .tx_er(link.tx_er), .txd_rise(link.txd_rise),
    .txd_fall(link.txd_fall), .rxc(link.rxc), .rx_dv(link.rx_dv),
    .rx_er(link.rx_er), .rxd_rise(link.rxd_rise),
    .rxd_fall(link.rxd_fall), .clk_stop_ok(link.clk_stop_ok));
  // ------------------------------------------------------------
  // shared tasks
  // ------------------------------------------------------------
  task automatic chk(input string nm, input logic [7:0] e, logic [7:0] g);
    cmp_count++;
    if (g !== e) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk_in);
    #1;
  endtask : tick
  task automatic rtick(input int n);
    repeat (n) @(posedge rx_clk);
    #1;
  endtask : rtick
  // holds the byte until it is taken; the caller drops valid
  task automatic send(input logic [7:0] d);
    int n;
    n = 0;
    tx_data  = d;
    tx_valid = 1'b1;
    while (ready !== 1'b1 && n < 50) begin
      tick(1);
      n++;
    end
    tick(1);
  endtask : send
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : end_of_test
  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_tx_data(input logic [7:0] d0, input logic [7:0] d1);
    logic [7:0] m;
    m = gig ? 8'hFF : 8'h0F;
    got_q.delete();
    send(d0);
    send(d1);
    tx_valid = 1'b0;
    tick(12);
    chk("tx count", 8'h02, 8'(got_q.size()));
    chk("tx byte0", d0 & m, got_q[0] & m);
    chk("tx byte1", d1 & m, got_q[1] & m);
  endtask : t_tx_data
  task automatic t_tx_lpi();
    int n;
    lpi_req = 1'b1;
    for (n = 0; n < 100 && tx_lpi !== 1'b1; n++) tick(1);
    chk("tx lpi on", 8'h01, {7'h0, tx_lpi});
    chk("rx lpi idle", 8'h00, {7'h0, rx_lpi});
    chk("ready in lpi", 8'h00, {7'h0, ready});
    for (n = 0; n < 100 && stopped !== 1'b1; n++) tick(1);
    chk("txc stopped", 8'h01, {7'h0, stopped});
    for (n = 0; n < 200 && burst !== 1'b1; n++) rtick(1);
    for (n = 0; n < 50 && burst === 1'b1; n++) rtick(1);
    chk("burst len", 8'(RF), 8'(n));
    for (n = 0; n < 50 && burst === 1'b0; n++) rtick(1);
    chk("quiet len", 8'(QT), 8'(n));
    tick(1);
    lpi_req = 1'b0;
    for (n = 0; n < 100 && tx_lpi !== 1'b0; n++) tick(1);
    chk("tx lpi off", 8'h00, {7'h0, tx_lpi});
    t_tx_data(8'h01, 8'hD2);
  endtask : t_tx_lpi
  task automatic t_rx_lpi();
    int n;
    int e;
    rtick(1);
    code = CODE_REFRESH;
    for (n = 0; n < 20 && rx_lpi !== 1'b1; n++) rtick(1);
    chk("rx lpi on", 8'h01, {7'h0, rx_lpi});
    chk("rx ctl", 8'h01, {7'h0, link.rx_er & ~link.rx_dv});
    chk("rxd", 8'h01, {link.rxd_fall, link.rxd_rise});
    chk("tx lpi idle", 8'h00, {7'h0, tx_lpi});
    rtick(14);
    e = rxc_edges;
    rtick(4);
    chk("rxc edges", stop_en ? 8'h00 : 8'h04, 8'(rxc_edges - e));
    chk("mac saw lpi", 8'h01, {7'h0, rx_seen});
    ldata = 8'hC3;
    code  = CODE_DATA;
    for (n = 0; n < 10 && rx_lpi !== 1'b0; n++) rtick(1);
    chk("rx lpi off", 8'h00, {7'h0, rx_lpi});
    for (n = 0; n < 10 && link.rx_dv !== 1'b1; n++) rtick(1);
    chk("rx data", gig ? 8'hC3 : 8'h03,
        {link.rxd_fall, link.rxd_rise});
    code = CODE_IDLE;
    rtick(4);
  endtask : t_rx_lpi
  task automatic t_eee();
    rtick(1);
    adv1000 = 1'b0;
    restart = 1'b1;
    rtick(1);
    restart = 1'b0;
    rtick(4);
    chk("eee one adv", 8'h01, {7'h0, eee});
    adv100  = 1'b0;
    restart = 1'b1;
    rtick(1);
    restart = 1'b0;
    rtick(4);
    chk("eee off", 8'h00, {7'h0, eee});
    code = CODE_REFRESH;
    rtick(3);
    chk("lpi eee off", 8'h00, {7'h0, rx_lpi});
    code = CODE_IDLE;
    rtick(2);
  endtask : t_eee
  initial begin
    repeat (6) @(posedge ref_clk_in);
    #1 rst_in = 1'b0;
    tick(3);
    chk("eee reset", 8'h01, {7'h0, eee});
    for (int g = 1; g >= 0; g--) begin
      gig = g[0];
      tick(4);
      t_tx_data(8'hA5, 8'h3C);
      t_tx_lpi();
      t_rx_lpi();
    end
    // clock stop disabled: rxc keeps running, lpi left straight to normal
    stop_en = 1'b0;
    t_rx_lpi();
    stop_en = 1'b1;
    t_eee();
    end_of_test();
  end
  initial begin
    #400000;
    bad_count++;
    end_of_test();
  end
endmodule : rgmii_eee_lpi_signaling_tb
